//--- fsdiag_pkg.sv
// Constants for the diagnostic event logic of an eight-channel fail-safe output module.
// Holds the fault codes, source indexes and vector sizes that the event module needs.
package fsdiag_pkg;

    // Fault codes are carried unchanged in decimal, so ten bits are enough for 802.
    localparam int CODE_W = 10;
    localparam int CH_N = 8;
    localparam int CH_W = 3;

    // Module-scoped sources. The first four are produced inside the event module.
    localparam int MOD_N = 25;
    localparam int MOD_EXT_N = 21;
    localparam int MI_TEMP = 0;
    localparam int MI_SAFETY = 1;
    localparam int MI_PARAM = 2;
    localparam int MI_SUPPLY = 3;
    localparam int MI_FIRST_EXT = 4;
    localparam logic [CODE_W-1:0] MOD_CODE [0:MOD_N-1] = '{
        10'd5, 10'd25, 10'd16, 10'd17,
        10'd64, 10'd65, 10'd66, 10'd67, 10'd68, 10'd69, 10'd70, 10'd71,
        10'd73, 10'd74, 10'd75, 10'd76, 10'd77, 10'd78,
        10'd256, 10'd259, 10'd283, 10'd781, 10'd786, 10'd801, 10'd802
    };

    // Channel-scoped sources, one set per channel.
    localparam int CK_N = 8;
    localparam int CK_OPEN = 0;
    localparam int CK_SHORT_SUP = 1;
    localparam int CK_SHORT_GND = 2;
    localparam int CK_ACK_WAIT = 3;
    localparam int CK_FREQ = 4;
    localparam int CK_DEFECT = 5;
    localparam int CK_READBACK = 6;
    localparam int CK_OVERLOAD = 7;
    localparam logic [CODE_W-1:0] CH_CODE [0:CK_N-1] = '{
        10'd6, 10'd261, 10'd262, 10'd779, 10'd785, 10'd797, 10'd798, 10'd800
    };

    // Total number of pending event bits.
    localparam int SRC_N = MOD_N + CH_N * CK_N;
    localparam int SRC_W = 7;

    // Codes referred to by checks.
    localparam logic [CODE_W-1:0] CODE_TEMP = 10'd5;
    localparam logic [CODE_W-1:0] CODE_PARAM = 10'd16;
    localparam logic [CODE_W-1:0] CODE_SUPPLY = 10'd17;
    localparam logic [CODE_W-1:0] CODE_SHORT_MIN = 10'd261;

endpackage : fsdiag_pkg

//--- fsdiag_events.sv
// Diagnostic event logic: turns detected faults into one diagnostic interrupt each.
// Assumes the fault detectors deliver one-cycle pulses, or levels where noted, on clock_in.
// Notes on behaviour
// - One interrupt per detected alarm occurrence.
// - Each interrupt tagged channel with index, or module.
// - Parameter faults coded 64 to 71 and 76.
// - Overtemperature reported as module code 5, always.
// - Overtemperature fault latches until power cycle.
// - Open load reported as channel code 6.
// - Open load detection disableable per channel.
// - Bad or missing parameters give code 16.
// - Short-circuits 261/262, alarms enableable per channel.
// - Link checksum 77, watchdog expiry 78.
// - Stored set faults coded 73, 74, 75.
// - Channel codes 779, 785, 797, 798, 800.
// - Hardware codes 256 to 802, module scope.
// - Shared output: open load only if several.
// - Missing load supply gives module code 17.
// - Healthy channels switched off, code 25 reported.
`timescale 1ns/10ps
module fsdiag_events import fsdiag_pkg::*; (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Module-level fault inputs.
    input wire logic over_temp_in,
    input wire logic param_assigned_in,
    input wire logic param_error_in,
    input wire logic supply_ok_in,
    input wire logic [MOD_EXT_N-1:0] module_event_in,
    // Channel fault pulses, one bit per channel.
    input wire logic [CH_N-1:0] open_load_any_in,
    input wire logic [CH_N-1:0] open_load_multi_in,
    input wire logic [CH_N-1:0] short_supply_in,
    input wire logic [CH_N-1:0] short_ground_in,
    input wire logic [CH_N-1:0] ack_wait_in,
    input wire logic [CH_N-1:0] freq_high_in,
    input wire logic [CH_N-1:0] output_defect_in,
    input wire logic [CH_N-1:0] readback_in,
    input wire logic [CH_N-1:0] overload_in,
    // Channel configuration levels.
    input wire logic [CH_N-1:0] shared_output_in,
    input wire logic [CH_N-1:0] open_load_en_in,
    input wire logic [CH_N-1:0] short_en_in,
    // Controller actions.
    input wire logic [CH_N-1:0] chan_ack_in,
    input wire logic reintegrate_in,
    // Interrupt toward the controller.
    output logic irq_valid_out,
    output logic [CODE_W-1:0] irq_code_out,
    output logic irq_scope_chan_out,
    output logic [CH_W-1:0] irq_channel_out,
    // Module status.
    output logic temp_faulted_out,
    output logic passivated_out,
    output logic [CH_N-1:0] chan_enable_out
);

    logic [SRC_N-1:0] pend_q, pend_d;
    logic [SRC_N-1:0] ev_vec;
    logic [SRC_N-1:0] grant;
    logic [MOD_N-1:0] mod_ev;
    logic [CH_N-1:0] ev_open, ev_short, ch_fault_ev;
    logic temp_q, temp_d;
    logic unassigned_q, unassigned_d;
    logic supply_bad_q, supply_bad_d;
    logic passive_q, passive_d;
    logic [CH_N-1:0] ch_fault_q, ch_fault_d;
    logic [CH_N-1:0] ch_off_q, ch_off_d;
    logic [CH_N-1:0] en_q, en_d;
    logic safety_ev;
    logic irq_v_q, irq_v_d;
    logic [CODE_W-1:0] irq_c_q, irq_c_d;
    logic irq_s_q, irq_s_d;
    logic [CH_W-1:0] irq_ch_q, irq_ch_d;

    // Event gathering. Level faults raise one event on entry, not one per cycle.
    always_comb begin
        temp_d = temp_q | over_temp_in;
        unassigned_d = ~param_assigned_in;
        supply_bad_d = ~supply_ok_in;
        // Open load on a shared output is only credible when several loads report it.
        ev_open = open_load_en_in
                  & (open_load_multi_in | (open_load_any_in & ~shared_output_in));
        ev_short = (short_supply_in | short_ground_in) & short_en_in;
        ch_fault_ev = ev_short | output_defect_in | readback_in | overload_in;
        // An enabled short, defect, readback or overload fault on one channel switches off every other channel still healthy.
        ch_fault_d = (ch_fault_q & ~chan_ack_in) | ch_fault_ev;
        // Reintegration clears the switch-offs first, so a fault in the same cycle still wins.
        ch_off_d = ch_off_q;
        if (reintegrate_in && !temp_q) begin
            ch_off_d = '0;
        end
        safety_ev = 1'b0;
        if (ch_fault_ev != '0) begin
            safety_ev = ((~ch_fault_d & ~ch_off_d) != '0);
            ch_off_d = ch_off_d | ~ch_fault_d;
        end
        mod_ev = '0;
        mod_ev[MI_TEMP] = over_temp_in & ~temp_q;
        mod_ev[MI_SAFETY] = safety_ev;
        mod_ev[MI_PARAM] = param_error_in | (~param_assigned_in & ~unassigned_q);
        mod_ev[MI_SUPPLY] = ~supply_ok_in & ~supply_bad_q;
        for (int i = 0; i < MOD_EXT_N; i++) begin
            mod_ev[MI_FIRST_EXT + i] = module_event_in[i];
        end
        ev_vec = '0;
        ev_vec[MOD_N-1:0] = mod_ev;
        for (int c = 0; c < CH_N; c++) begin
            ev_vec[MOD_N + c*CK_N + CK_OPEN] = ev_open[c];
            ev_vec[MOD_N + c*CK_N + CK_SHORT_SUP] = short_supply_in[c] & short_en_in[c];
            ev_vec[MOD_N + c*CK_N + CK_SHORT_GND] = short_ground_in[c] & short_en_in[c];
            ev_vec[MOD_N + c*CK_N + CK_ACK_WAIT] = ack_wait_in[c];
            ev_vec[MOD_N + c*CK_N + CK_FREQ] = freq_high_in[c];
            ev_vec[MOD_N + c*CK_N + CK_DEFECT] = output_defect_in[c];
            ev_vec[MOD_N + c*CK_N + CK_READBACK] = readback_in[c];
            ev_vec[MOD_N + c*CK_N + CK_OVERLOAD] = overload_in[c];
        end
        // Any module fault passivates; release waits for the controller while the
        // temperature latch is clear. The set term is applied last so it wins.
        passive_d = passive_q;
        if (reintegrate_in && !temp_q) begin
            passive_d = 1'b0;
        end
        if (mod_ev != '0 || temp_d) begin
            passive_d = 1'b1;
        end
        en_d = ~(ch_off_d | ch_fault_d) & {CH_N{~passive_d}};
    end

    // Arbiter: lowest pending index first, so module alarms lead channel alarms.
    // Pending bits queue simultaneous events; a new event on the granted bit survives.
    always_comb begin
        grant = '0;
        irq_v_d = 1'b0;
        irq_c_d = '0;
        irq_s_d = 1'b0;
        irq_ch_d = '0;
        for (int i = SRC_N - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
        for (int i = 0; i < SRC_N; i++) begin
            if (grant[i]) begin
                irq_v_d = 1'b1;
                if (i < MOD_N) begin
                    irq_c_d = MOD_CODE[i];
                end else begin
                    irq_c_d = CH_CODE[(i - MOD_N) % CK_N];
                    irq_s_d = 1'b1;
                    irq_ch_d = CH_W'((i - MOD_N) / CK_N);
                end
            end
        end
        pend_d = (pend_q & ~grant) | ev_vec;
    end

    // State registers; the temperature latch is cleared only by reset (power cycle).
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pend_q <= '0;
            temp_q <= 1'b0;
            unassigned_q <= 1'b0;
            supply_bad_q <= 1'b0;
            passive_q <= 1'b1;
            ch_fault_q <= '0;
            ch_off_q <= '0;
            en_q <= '0;
            irq_v_q <= 1'b0;
            irq_c_q <= '0;
            irq_s_q <= 1'b0;
            irq_ch_q <= '0;
        end else begin
            pend_q <= pend_d;
            temp_q <= temp_d;
            unassigned_q <= unassigned_d;
            supply_bad_q <= supply_bad_d;
            passive_q <= passive_d;
            ch_fault_q <= ch_fault_d;
            ch_off_q <= ch_off_d;
            en_q <= en_d;
            irq_v_q <= irq_v_d;
            irq_c_q <= irq_c_d;
            irq_s_q <= irq_s_d;
            irq_ch_q <= irq_ch_d;
        end
    end

    // Outputs come straight from the registers.
    assign irq_valid_out = irq_v_q;
    assign irq_code_out = irq_c_q;
    assign irq_scope_chan_out = irq_s_q;
    assign irq_channel_out = irq_ch_q;
    assign temp_faulted_out = temp_q;
    assign passivated_out = passive_q;
    assign chan_enable_out = en_q;

    // Checks on the event path.
    property p_temp_latch;
        @(posedge clock_in) disable iff (rst_in) temp_q |=> temp_q;
    endproperty
    a_temp_latch: assert property (p_temp_latch) else $error("temperature latch released");

    property p_temp_irq;
        @(posedge clock_in) disable iff (rst_in)
            (over_temp_in && !temp_q) |-> ##[1:2] (irq_v_q && irq_c_q == CODE_TEMP && !irq_s_q);
    endproperty
    a_temp_irq: assert property (p_temp_irq) else $error("no code 5 after overtemperature");

    property p_open_disabled;
        @(posedge clock_in) disable iff (rst_in) (ev_open & ~open_load_en_in) == '0;
    endproperty
    a_open_disabled: assert property (p_open_disabled) else $error("open load on disabled channel");

    property p_shared_single;
        @(posedge clock_in) disable iff (rst_in)
            (ev_open & shared_output_in & ~open_load_multi_in) == '0;
    endproperty
    a_shared_single: assert property (p_shared_single) else $error("single open load on shared");

    property p_short_enable;
        @(posedge clock_in) disable iff (rst_in)
            (irq_v_q && irq_s_q && irq_c_q >= CODE_SHORT_MIN && irq_c_q <= CODE_SHORT_MIN + 10'd1)
            |-> ((($past(short_en_in, 2) | $past(short_en_in, 1)) >> irq_ch_q) & 8'h01) != 8'h00;
    endproperty
    a_short_enable: assert property (p_short_enable) else $error("short alarm while disabled");

    property p_grant;
        @(posedge clock_in) disable iff (rst_in) (pend_q != '0) |=> irq_v_q && irq_c_q != '0;
    endproperty
    a_grant: assert property (p_grant) else $error("pending alarm not issued");

    property p_scope;
        @(posedge clock_in) disable iff (rst_in) (irq_v_q && !irq_s_q) |-> irq_ch_q == '0;
    endproperty
    a_scope: assert property (p_scope) else $error("module alarm with channel index");

    property p_param;
        @(posedge clock_in) disable iff (rst_in)
            (!param_assigned_in && !unassigned_q) |-> ##[1:4] (irq_v_q && irq_c_q == CODE_PARAM);
    endproperty
    a_param: assert property (p_param) else $error("missing parameters not reported");

    property p_supply;
        @(posedge clock_in) disable iff (rst_in)
            (!supply_ok_in && !supply_bad_q) |-> ##[1:5] (irq_v_q && irq_c_q == CODE_SUPPLY);
    endproperty
    a_supply: assert property (p_supply) else $error("missing supply not reported");

    property p_safety_off;
        @(posedge clock_in) disable iff (rst_in)
            (safety_ev && !reintegrate_in) |=> (ch_off_q != '0) && (en_q & ch_off_q) == '0;
    endproperty
    a_safety_off: assert property (p_safety_off) else $error("healthy channels not switched off");

endmodule : fsdiag_events

//--- fsdiag_ctrl_model.sv
// Controller model: counts diagnostic interrupts, acknowledges channel faults, reintegrates.
// Assumes it shares clock_in and rst_in with the event block.
`timescale 1ns/10ps
module fsdiag_ctrl_model import fsdiag_pkg::*; (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Interrupt from the block.
    input wire logic irq_valid_in,
    input wire logic irq_scope_chan_in,
    input wire logic [CH_W-1:0] irq_channel_in,
    // Request from the bench.
    input wire logic reint_req_in,
    // Actions toward the block.
    output logic [CH_N-1:0] chan_ack_out,
    output logic reintegrate_out,
    output logic [15:0] irq_count_out
);
    // The bench removes a fault before its interrupt lands, so acknowledging at once is safe.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            chan_ack_out <= '0;
            reintegrate_out <= 1'b0;
            irq_count_out <= 16'h0000;
        end else begin
            chan_ack_out <= '0;
            reintegrate_out <= reint_req_in;
            if (irq_valid_in) begin
                irq_count_out <= irq_count_out + 16'h0001;
            end
            if (irq_valid_in && irq_scope_chan_in) begin
                chan_ack_out[irq_channel_in] <= 1'b1;
            end
        end
    end
endmodule : fsdiag_ctrl_model

//--- failsafe_output_diag_events_tb.sv
// Self-checking bench for the diagnostic event block with a controller model.
// Assumes inputs change on the falling edge and interrupts stand for one cycle.
`timescale 1ns/10ps
module failsafe_output_diag_events_tb import fsdiag_pkg::*;;
    logic clock_in, rst_in, over_temp_in, param_assigned_in, param_error_in, supply_ok_in;
    logic [MOD_EXT_N-1:0] modv;
    logic [CH_N-1:0] chf [0:8];
    logic [CH_N-1:0] shared_in, ol_en, sh_en, ack;
    logic reint_req, reint, irq_valid_out, irq_scope_chan_out, temp_faulted_out, passivated_out;
    logic [CODE_W-1:0] irq_code_out;
    logic [CH_W-1:0] irq_channel_out;
    logic [CH_N-1:0] chan_enable_out;
    logic [15:0] irq_count;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    localparam int MOD_EXP [0:20] = '{64, 65, 66, 67, 68, 69, 70, 71, 73, 74, 75, 76, 77, 78,
        256, 259, 283, 781, 786, 801, 802};

    fsdiag_events uut (.clock_in(clock_in), .rst_in(rst_in), .over_temp_in(over_temp_in),
        .param_assigned_in(param_assigned_in), .param_error_in(param_error_in),
        .supply_ok_in(supply_ok_in), .module_event_in(modv), .open_load_any_in(chf[0]),
        .open_load_multi_in(chf[8]), .short_supply_in(chf[1]), .short_ground_in(chf[2]),
        .ack_wait_in(chf[3]), .freq_high_in(chf[4]), .output_defect_in(chf[5]),
        .readback_in(chf[6]), .overload_in(chf[7]), .shared_output_in(shared_in),
        .open_load_en_in(ol_en), .short_en_in(sh_en), .chan_ack_in(ack),
        .reintegrate_in(reint), .irq_valid_out(irq_valid_out), .irq_code_out(irq_code_out),
        .irq_scope_chan_out(irq_scope_chan_out), .irq_channel_out(irq_channel_out),
        .temp_faulted_out(temp_faulted_out), .passivated_out(passivated_out),
        .chan_enable_out(chan_enable_out));
    fsdiag_ctrl_model ctrl (.clock_in(clock_in), .rst_in(rst_in), .irq_valid_in(irq_valid_out),
        .irq_scope_chan_in(irq_scope_chan_out), .irq_channel_in(irq_channel_out),
        .reint_req_in(reint_req), .chan_ack_out(ack), .reintegrate_out(reint),
        .irq_count_out(irq_count));

    // A 50 MHz clock.
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    // The whole run needs well under a thousand cycles, so this ceiling only catches hangs.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk

    // Waits a bounded time for the next interrupt and compares all its fields.
    task automatic expect_irq(input int code, input logic scope, input int ch);
        int n;
        n = 0;
        while (irq_valid_out !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
        end
        chk("irq_valid", 16'h0001, {15'h0000, irq_valid_out});
        chk("irq_code", code[15:0], {6'h00, irq_code_out});
        chk("irq_scope", {15'h0000, scope}, {15'h0000, irq_scope_chan_out});
        chk("irq_channel", ch[15:0], {13'h0000, irq_channel_out});
        @(negedge clock_in);
    endtask : expect_irq

    // Checks that no interrupt at all appears for n cycles.
    task automatic quiet(input int n);
        logic [15:0] c0;
        c0 = irq_count;
        repeat (n) @(negedge clock_in);
        chk("irq_count", c0, irq_count);
    endtask : quiet

    task automatic pulse_ch(input int k, input int c);
        @(negedge clock_in);
        chf[k][c] = 1'b1;
        @(negedge clock_in);
        chf[k][c] = 1'b0;
    endtask : pulse_ch

    task automatic reintegrate();
        @(negedge clock_in);
        reint_req = 1'b1;
        @(negedge clock_in);
        reint_req = 1'b0;
        repeat (3) @(negedge clock_in);
    endtask : reintegrate

    task automatic t_module();
        for (int i = 0; i < MOD_EXT_N; i++) begin
            @(negedge clock_in);
            modv[i] = 1'b1;
            @(negedge clock_in);
            modv = '0;
            expect_irq(MOD_EXP[i], 1'b0, 0);
        end
        @(negedge clock_in);
        modv = 21'h100001;
        @(negedge clock_in);
        modv = '0;
        expect_irq(64, 1'b0, 0);
        expect_irq(802, 1'b0, 0);
        @(negedge clock_in);
        param_error_in = 1'b1;
        @(negedge clock_in);
        param_error_in = 1'b0;
        expect_irq(16, 1'b0, 0);
        param_assigned_in = 1'b0;
        expect_irq(16, 1'b0, 0);
        param_assigned_in = 1'b1;
        supply_ok_in = 1'b0;
        expect_irq(17, 1'b0, 0);
        quiet(5);
        supply_ok_in = 1'b1;
        $display("test module codes done");
    endtask : t_module

    task automatic t_channel();
        reintegrate();
        chk("passivated", 16'h0000, {15'h0000, passivated_out});
        chk("chan_enable", 16'h00ff, {8'h00, chan_enable_out});
        pulse_ch(7, 3);
        expect_irq(25, 1'b0, 0);
        expect_irq(800, 1'b1, 3);
        chk("chan_enable5", 16'h0000, {15'h0000, chan_enable_out[5]});
        for (int k = 3; k < 7; k++) begin
            pulse_ch(k, 5);
            // The defect switches off channel 3, healthy again after its acknowledgment.
            if (k == CK_DEFECT) expect_irq(25, 1'b0, 0);
            expect_irq(CH_CODE[k], 1'b1, 5);
        end
        sh_en[1] = 1'b0;
        pulse_ch(1, 1);
        quiet(5);
        sh_en[1] = 1'b1;
        pulse_ch(1, 1);
        expect_irq(261, 1'b1, 1);
        pulse_ch(2, 1);
        expect_irq(262, 1'b1, 1);
        $display("test channel codes done");
    endtask : t_channel

    task automatic t_open();
        ol_en[2] = 1'b0;
        pulse_ch(0, 2);
        quiet(5);
        ol_en[2] = 1'b1;
        pulse_ch(0, 2);
        expect_irq(6, 1'b1, 2);
        shared_in[2] = 1'b1;
        pulse_ch(0, 2);
        quiet(5);
        // Several loads open: both reports arrive as one pulse in the same cycle.
        @(negedge clock_in);
        chf[0][2] = 1'b1;
        chf[8][2] = 1'b1;
        @(negedge clock_in);
        chf[0][2] = 1'b0;
        chf[8][2] = 1'b0;
        expect_irq(6, 1'b1, 2);
        $display("test open load done");
    endtask : t_open

    task automatic t_temp();
        over_temp_in = 1'b1;
        expect_irq(5, 1'b0, 0);
        over_temp_in = 1'b0;
        reintegrate();
        chk("temp_faulted", 16'h0001, {15'h0000, temp_faulted_out});
        chk("passivated", 16'h0001, {15'h0000, passivated_out});
        // A power cycle is the only way out of the temperature latch.
        rst_in = 1'b1;
        repeat (2) @(negedge clock_in);
        rst_in = 1'b0;
        @(negedge clock_in);
        chk("temp_after_reset", 16'h0000, {15'h0000, temp_faulted_out});
        $display("test temperature done");
    endtask : t_temp

    // Main sequence: every input gets a value at time zero, reset is held 16 cycles.
    initial begin
        rst_in = 1'b1;
        {over_temp_in, param_error_in, reint_req, modv, shared_in} = '0;
        param_assigned_in = 1'b1;
        supply_ok_in = 1'b1;
        ol_en = 8'hff;
        sh_en = 8'hff;
        for (int k = 0; k < 9; k++) chf[k] = '0;
        repeat (16) @(negedge clock_in);
        chk("reset_passivated", 16'h0001, {15'h0000, passivated_out});
        chk("code_width", 16'h000a, 16'($bits(irq_code_out)));
        rst_in = 1'b0;
        quiet(4);
        t_module();
        t_channel();
        t_open();
        t_temp();
        end_sim();
    end
endmodule : failsafe_output_diag_events_tb
